// [design/acc_pkg.sv]
// constants and types shared by the converter control block
package acc_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RES_W = 12;
  localparam int PINS = 8;
  localparam int CNT_W = 6;

  // register offsets
  localparam logic [2:0] REG_CTRL0 = 3'h0;
  localparam logic [2:0] REG_CTRL1 = 3'h1;
  localparam logic [2:0] REG_SENSOR = 3'h2;
  localparam logic [2:0] REG_RES_HI = 3'h3;
  localparam logic [2:0] REG_RES_LO = 3'h4;
  localparam logic [2:0] REG_PSEL_LO = 3'h5;
  localparam logic [2:0] REG_PSEL_HI = 3'h6;
  localparam logic [2:0] REG_INT = 3'h7;

  // conv_ctrl_zero fields
  localparam int B_START = 7;
  localparam int B_BUSY = 6;
  localparam int B_POWER = 5;
  localparam int B_CHAN = 0;
  localparam int W_CHAN = 4;
  // conv_ctrl_one fields
  localparam int B_FMT = 7;
  localparam int B_REFS = 6;
  localparam int B_CLKSEL = 0;
  localparam int W_CLKSEL = 3;
  // sensor control fields
  localparam int B_TSE = 0;
  localparam int B_PTAT = 1;
  localparam int B_GAIN = 2;
  localparam int B_DESEL = 3;
  // interrupt control fields
  localparam int B_FLAG = 0;
  localparam int B_ADE = 1;
  localparam int B_EMI = 2;

  // pin function code that hands a pin to the converter
  localparam logic [1:0] PIN_FUNC_ANALOG = 2'h3;
  localparam int PIN_FUNC_W = 2;

  // reference selection codes driven to the core
  localparam logic [1:0] REF_PIN = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_SENSOR = 2'h2;

  // phase lengths in converter clock cycles
  localparam logic [CNT_W-1:0] SAMPLE_EXT = 6'h04;
  localparam logic [CNT_W-1:0] CONV_CYC = 6'h0c;
  localparam logic [CNT_W-1:0] TOTAL_EXT = 6'h10;
  localparam logic [CNT_W-1:0] TOTAL_TEMP = 6'h38;
  localparam logic [CNT_W-1:0] SAMPLE_TEMP = TOTAL_TEMP - CONV_CYC;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

  localparam int DIV_W = 7;
  localparam logic [DIV_W-1:0] DIV_ONE = 7'h01;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_SAMPLE = 3'b010,
    ACC_CONVERT = 3'b100
  } acc_state_e;
endpackage

// [design/acc_clk_div.sv]
// converter clock divider: power-of-two tick from the system clock
`timescale 1ns/100ps
module acc_clk_div
  import acc_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic enable_in, // converter powered
  input wire logic [acc_pkg::W_CLKSEL-1:0] sel_in, // 0 undivided .. 7 /128
  output logic tick_out // one-cycle converter clock tick
);
  import acc_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } acc_div_s;

  acc_div_s s_r;
  acc_div_s s_nxt;
  logic [DIV_W-1:0] mask;

  always_comb begin
    mask = DIV_W'((DIV_ONE << sel_in) - DIV_ONE);
    s_nxt = s_r;
    if (!enable_in) begin
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b0;
    end else begin
      s_nxt.tick = ((s_r.cnt & mask) == mask);
      s_nxt.cnt = DIV_W'(s_r.cnt + DIV_ONE);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_out = s_r.tick;
endmodule

// [design/acc_top.sv]
// converter control: registers, pin override, sequencing, results
//
// What this block does
// - analog pin selection disables other pin functions
// - analog pin drops its pull-up
// - analog pin ignores port direction setting
// - reference from pin, supply or sensor
// - sample 4 cycles (44 for temperature), then convert 12
// - external conversion takes 16 converter cycles
// - temperature conversion takes 56 converter cycles
// - converter clock from system clock by select
// - format bit sets result alignment
// - start bit low-high-low begins conversion
// - busy high during conversion, result after
// - power bit clear switches converter off
// - result twelve bits, full scale all ones
// - select 000 undivided up to /128
// - completion sets request flag, raises interrupt
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module acc_top
  import acc_pkg::*;
(
  input wire logic ref_clk_in, // 40 MHz system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic [acc_pkg::ADDR_W-1:0] reg_addr_in, // register address
  input wire logic [acc_pkg::DATA_W-1:0] reg_wdata_in, // write data
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  output logic [acc_pkg::DATA_W-1:0] reg_rdata_out, // read data, next cycle
  output logic conv_irq_out, // converter interrupt level
  input wire logic [acc_pkg::PINS-1:0] port_oe_in, // port direction, 1 out
  input wire logic [acc_pkg::PINS-1:0] port_pullup_in, // software pull-ups
  input wire logic [acc_pkg::PINS-1:0] port_data_in, // port output data
  output logic [acc_pkg::PINS-1:0] pin_oe_out, // pin drive enable
  output logic [acc_pkg::PINS-1:0] pin_data_out, // pin drive data
  output logic [acc_pkg::PINS-1:0] pin_pullup_out, // pull-up connect
  output logic [acc_pkg::PINS-1:0] pin_analog_out, // pin routed to converter
  input wire logic [acc_pkg::RES_W-1:0] core_result_in, // core result word
  output logic core_power_out, // analog core power
  output logic core_sample_out, // sampling phase
  output logic core_convert_out, // conversion phase
  output logic core_ext_en_out, // external input routed
  output logic core_temp_en_out, // sensor signal routed
  output logic [2:0] core_channel_out, // external or sensor channel
  output logic [1:0] core_ref_sel_out, // reference source code
  output logic core_ref_ptat_out, // sensor ref source bit
  output logic core_ref_gain_out, // sensor ref gain bit
  output logic conv_tick_out // converter clock tick
);
  import acc_pkg::*;

  typedef struct packed {
    acc_state_e st;
    logic [CNT_W-1:0] cnt;
    logic temp;
    logic start;
    logic power;
    logic [W_CHAN-1:0] chan;
    logic fmt;
    logic refs;
    logic [W_CLKSEL-1:0] clksel;
    logic temp_sensor_route;
    logic ptat;
    logic gain;
    logic desel;
    logic [PINS*PIN_FUNC_W/2-1:0] psel_lo;
    logic [PINS*PIN_FUNC_W/2-1:0] psel_hi;
    logic flag;
    logic ade;
    logic global_int_enable;
    logic [RES_W-1:0] res;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic [PINS-1:0] pin_oe;
    logic [PINS-1:0] pin_do;
    logic [PINS-1:0] pin_pu;
    logic [PINS-1:0] pin_an;
    logic sample;
    logic convert;
    logic ext_en;
    logic temp_en;
    logic [2:0] ch;
    logic [1:0] ref_sel;
    logic tick;
  } acc_state_s;

  acc_state_s s_r;
  acc_state_s s_nxt;
  logic tick;
  logic wr;
  logic launch;
  logic done;
  logic busy;
  logic sensor_sel;
  logic [CNT_W-1:0] sample_len;
  logic [PINS*PIN_FUNC_W-1:0] psel_all;
  logic [2*DATA_W-1:0] res_al;

  // true when a pin's function code hands it to the converter
  function automatic logic pin_is_analog(
    input logic [PINS*PIN_FUNC_W-1:0] sel,
    input int idx
  );
    pin_is_analog = (sel[idx*PIN_FUNC_W +: PIN_FUNC_W] == PIN_FUNC_ANALOG);
  endfunction

  // result alignment for the high and low bytes
  function automatic logic [2*DATA_W-1:0] align_result(
    input logic [RES_W-1:0] r,
    input logic fmt
  );
    if (fmt) begin
      align_result = {4'h0, r};
    end else begin
      align_result = {r, 4'h0};
    end
  endfunction

  acc_clk_div u_div (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(s_r.power),
    .sel_in(s_r.clksel),
    .tick_out(tick)
  );

  always_comb begin
    s_nxt = s_r;
    wr = reg_wr_in;
    busy = (s_r.st != ACC_IDLE);
    psel_all = {s_r.psel_hi, s_r.psel_lo};
    res_al = align_result(s_r.res, s_r.fmt);
    sample_len = s_r.temp ? SAMPLE_TEMP : SAMPLE_EXT;
    sensor_sel = s_r.temp_sensor_route && s_r.chan[W_CHAN-1];
    done = 1'b0;
    launch = 1'b0;

    // register writes
    if (wr) begin
      unique case (reg_addr_in)
        REG_CTRL0: begin
          s_nxt.start = reg_wdata_in[B_START];
          s_nxt.power = reg_wdata_in[B_POWER];
          s_nxt.chan = reg_wdata_in[B_CHAN +: W_CHAN];
          // falling edge of the start bit while powered
          launch = s_r.start && !reg_wdata_in[B_START] &&
                   reg_wdata_in[B_POWER];
        end
        REG_CTRL1: begin
          s_nxt.fmt = reg_wdata_in[B_FMT];
          s_nxt.refs = reg_wdata_in[B_REFS];
          s_nxt.clksel = reg_wdata_in[B_CLKSEL +: W_CLKSEL];
        end
        REG_SENSOR: begin
          s_nxt.temp_sensor_route = reg_wdata_in[B_TSE];
          s_nxt.ptat = reg_wdata_in[B_PTAT];
          s_nxt.gain = reg_wdata_in[B_GAIN];
          s_nxt.desel = reg_wdata_in[B_DESEL];
        end
        REG_PSEL_LO: s_nxt.psel_lo = reg_wdata_in;
        REG_PSEL_HI: s_nxt.psel_hi = reg_wdata_in;
        REG_INT: begin
          if (!reg_wdata_in[B_FLAG]) begin
            s_nxt.flag = 1'b0;
          end
          s_nxt.ade = reg_wdata_in[B_ADE];
          s_nxt.global_int_enable = reg_wdata_in[B_EMI];
        end
        default: begin
        end
      endcase
    end

    // conversion sequencer
    unique case (s_r.st)
      ACC_IDLE: begin
      end
      ACC_SAMPLE: begin
        if (tick) begin
          if (s_r.cnt == sample_len - CNT_ONE) begin
            s_nxt.st = ACC_CONVERT;
            s_nxt.cnt = CNT_ZERO;
          end else begin
            s_nxt.cnt = CNT_W'(s_r.cnt + CNT_ONE);
          end
        end
      end
      ACC_CONVERT: begin
        if (tick) begin
          if (s_r.cnt == CONV_CYC - CNT_ONE) begin
            done = 1'b1;
            s_nxt.st = ACC_IDLE;
            s_nxt.cnt = CNT_ZERO;
            s_nxt.res = core_result_in;
          end else begin
            s_nxt.cnt = CNT_W'(s_r.cnt + CNT_ONE);
          end
        end
      end
    endcase

    if (launch) begin
      // a new start also restarts a conversion under way
      s_nxt.st = ACC_SAMPLE;
      s_nxt.cnt = CNT_ZERO;
      s_nxt.temp = sensor_sel;
    end
    if (!s_nxt.power) begin
      s_nxt.st = ACC_IDLE;
      s_nxt.cnt = CNT_ZERO;
    end
    if (done && s_nxt.power) begin
      s_nxt.flag = 1'b1;
    end

    // read data, registered for the next cycle
    s_nxt.rdata = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        REG_CTRL0: begin
          s_nxt.rdata[B_START] = s_r.start;
          s_nxt.rdata[B_BUSY] = busy;
          s_nxt.rdata[B_POWER] = s_r.power;
          s_nxt.rdata[B_CHAN +: W_CHAN] = s_r.chan;
        end
        REG_CTRL1: begin
          s_nxt.rdata[B_FMT] = s_r.fmt;
          s_nxt.rdata[B_REFS] = s_r.refs;
          s_nxt.rdata[B_CLKSEL +: W_CLKSEL] = s_r.clksel;
        end
        REG_SENSOR: begin
          s_nxt.rdata[B_TSE] = s_r.temp_sensor_route;
          s_nxt.rdata[B_PTAT] = s_r.ptat;
          s_nxt.rdata[B_GAIN] = s_r.gain;
          s_nxt.rdata[B_DESEL] = s_r.desel;
        end
        REG_RES_HI: begin
          s_nxt.rdata = res_al[DATA_W +: DATA_W];
        end
        REG_RES_LO: begin
          s_nxt.rdata = res_al[0 +: DATA_W];
        end
        REG_PSEL_LO: s_nxt.rdata = s_r.psel_lo;
        REG_PSEL_HI: s_nxt.rdata = s_r.psel_hi;
        REG_INT: begin
          s_nxt.rdata[B_FLAG] = s_r.flag;
          s_nxt.rdata[B_ADE] = s_r.ade;
          s_nxt.rdata[B_EMI] = s_r.global_int_enable;
        end
      endcase
    end

    s_nxt.irq = s_nxt.flag && s_nxt.ade && s_nxt.global_int_enable;

    // pin override
    for (int i = 0; i < PINS; i++) begin
      s_nxt.pin_an[i] = pin_is_analog(psel_all, i);
      s_nxt.pin_oe[i] = !pin_is_analog(psel_all, i) && port_oe_in[i];
      s_nxt.pin_do[i] = !pin_is_analog(psel_all, i) && port_data_in[i];
      s_nxt.pin_pu[i] = !pin_is_analog(psel_all, i) && port_pullup_in[i];
    end

    // analog core controls
    s_nxt.sample = (s_nxt.st == ACC_SAMPLE);
    s_nxt.convert = (s_nxt.st == ACC_CONVERT);
    s_nxt.ext_en = s_nxt.power && !s_nxt.temp_sensor_route;
    s_nxt.temp_en = s_nxt.power && s_nxt.temp_sensor_route && s_nxt.chan[W_CHAN-1];
    s_nxt.ch = s_nxt.chan[2:0];
    if (!s_nxt.desel) begin
      s_nxt.ref_sel = REF_SENSOR;
    end else if (s_nxt.refs) begin
      s_nxt.ref_sel = REF_SUPPLY;
    end else begin
      s_nxt.ref_sel = REF_PIN;
    end
    // no stray tick from the divider once power drops
    s_nxt.tick = tick && s_nxt.power;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
      s_r.st <= ACC_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_out = s_r.rdata;
  assign conv_irq_out = s_r.irq;
  assign pin_oe_out = s_r.pin_oe;
  assign pin_data_out = s_r.pin_do;
  assign pin_pullup_out = s_r.pin_pu;
  assign pin_analog_out = s_r.pin_an;
  assign core_power_out = s_r.power;
  assign core_sample_out = s_r.sample;
  assign core_convert_out = s_r.convert;
  assign core_ext_en_out = s_r.ext_en;
  assign core_temp_en_out = s_r.temp_en;
  assign core_channel_out = s_r.ch;
  assign core_ref_sel_out = s_r.ref_sel;
  assign core_ref_ptat_out = s_r.ptat;
  assign core_ref_gain_out = s_r.gain;
  assign conv_tick_out = s_r.tick;
endmodule

// [sim/acc_core_model.sv]
// behavioural model of the analog sampling and conversion core
`timescale 1ns/100ps
module acc_core_model
  import acc_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic power_in, // core powered
  input wire logic convert_in, // conversion phase
  input wire logic temp_en_in, // sensor routed
  input wire logic [2:0] channel_in, // selected channel
  output logic [acc_pkg::RES_W-1:0] result_out // result word
);
  logic [acc_pkg::RES_W-1:0] idle_r = 12'h5a5;
  always @(posedge ref_clk_in) idle_r <= ~idle_r;
  always_comb begin
    if (!power_in || !convert_in)
      result_out = idle_r; // word not held outside conversion
    else if (!temp_en_in && channel_in == 3'h7)
      result_out = 12'hfff; // full-scale input
    else
      result_out = {temp_en_in, channel_in, 8'h5a};
  end
endmodule

// [sim/acc_props.sv]
// concurrent checks on the converter control ports
`timescale 1ns/100ps
module acc_props
  import acc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [acc_pkg::PINS-1:0] port_oe_in,
  input wire logic [acc_pkg::PINS-1:0] pin_oe_out,
  input wire logic [acc_pkg::PINS-1:0] pin_data_out,
  input wire logic [acc_pkg::PINS-1:0] pin_pullup_out,
  input wire logic [acc_pkg::PINS-1:0] pin_analog_out,
  input wire logic core_power_out,
  input wire logic core_sample_out,
  input wire logic core_convert_out,
  input wire logic core_ext_en_out,
  input wire logic core_temp_en_out,
  input wire logic [1:0] core_ref_sel_out,
  input wire logic conv_tick_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [1:0] up_r;
  logic [7:0] tk_r;
  // ticks seen while converting
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up_r <= 2'h0;
      tk_r <= 8'h00;
    end else begin
      up_r <= {up_r[0], 1'b1};
      tk_r <= core_convert_out ? tk_r + {7'h00, conv_tick_out} : 8'h00;
    end
  end
  a_pin_no_data: assert property ((pin_analog_out & pin_data_out) == '0)
    else $error("analog pin still drives data");
  a_pullup_drop: assert property ((pin_analog_out & pin_pullup_out) == '0)
    else $error("analog pin keeps pull-up");
  a_oe_follow: assert property (
    up_r[1] |-> pin_oe_out == ($past(port_oe_in) & ~pin_analog_out))
    else $error("pin enable mismatch");
  a_phase_excl: assert property (!(core_sample_out && core_convert_out))
    else $error("sample and convert together");
  a_conv_after: assert property (
    $rose(core_convert_out) |-> $past(core_sample_out))
    else $error("convert without sampling");
  a_conv_ticks: assert property (
    $fell(core_convert_out) && !core_sample_out && core_power_out
    |-> tk_r == 8'h0c)
    else $error("convert phase tick count wrong");
  a_route_excl: assert property (
    core_temp_en_out |-> core_power_out && !core_ext_en_out)
    else $error("both inputs routed");
  a_power_gate: assert property (
    !core_power_out && !$past(core_power_out) |-> !(core_sample_out ||
    core_convert_out || core_ext_en_out || core_temp_en_out || conv_tick_out))
    else $error("core active while unpowered");
  a_ref_code: assert property (core_ref_sel_out != 2'h3)
    else $error("bad reference code");
  c_done: cover property ($fell(core_convert_out) && !core_sample_out);
  c_temp: cover property (core_temp_en_out && core_sample_out);
  c_analog: cover property (pin_analog_out != '0);
endmodule

bind acc_top acc_props u_props (
  .ref_clk_in, .rst_n_in, .port_oe_in, .pin_oe_out, .pin_data_out,
  .pin_pullup_out, .pin_analog_out, .core_power_out, .core_sample_out,
  .core_convert_out, .core_ext_en_out, .core_temp_en_out,
  .core_ref_sel_out, .conv_tick_out
);

// [sim/acc_top_test.sv]
// self-checking bench for the converter control block
`timescale 1ns/100ps
module acc_top_test;
  import acc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] reg_addr_in = 3'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] port_oe_in = 8'hff;
  logic [7:0] port_pullup_in = 8'hff;
  logic [7:0] port_data_in = 8'hff;
  logic [7:0] reg_rdata_out, pin_oe_out, pin_data_out, pin_pullup_out;
  logic [7:0] pin_analog_out, d;
  logic [11:0] core_result_in;
  logic [2:0] core_channel_out;
  logic [1:0] core_ref_sel_out;
  logic conv_irq_out, core_power_out, core_sample_out, core_convert_out;
  logic core_ext_en_out, core_temp_en_out, core_ref_ptat_out;
  logic core_ref_gain_out, conv_tick_out;
  int err_total = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;
  int s, c, n;
  // address, write data, read-back
  logic [18:0] rows [6] = '{
    {REG_CTRL0, 8'h0f, 8'h0f}, {REG_CTRL1, 8'hff, 8'hc7},
    {REG_SENSOR, 8'hff, 8'h0f}, {REG_RES_HI, 8'hff, 8'h00},
    {REG_PSEL_LO, 8'h5a, 8'h5a}, {REG_INT, 8'hff, 8'h06}};

  acc_top dut (
    .ref_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .conv_irq_out, .port_oe_in,
    .port_pullup_in, .port_data_in, .pin_oe_out, .pin_data_out,
    .pin_pullup_out, .pin_analog_out, .core_result_in, .core_power_out,
    .core_sample_out, .core_convert_out, .core_ext_en_out,
    .core_temp_en_out, .core_channel_out, .core_ref_sel_out,
    .core_ref_ptat_out, .core_ref_gain_out, .conv_tick_out);
  acc_core_model u_core (
    .ref_clk_in, .power_in(core_power_out), .convert_in(core_convert_out),
    .temp_en_in(core_temp_en_out), .channel_in(core_channel_out),
    .result_out(core_result_in));

  always #12.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge ref_clk_in);
  endtask
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge ref_clk_in);
    v = reg_rdata_out;
  endtask
  task launch(input logic [7:0] ch);
    wr(REG_CTRL0, 8'h20 | ch);
    wr(REG_CTRL0, 8'ha0 | ch);
    wr(REG_CTRL0, 8'h20 | ch);
  endtask
  // counts sampling and converting cycles of one run
  task phase(output int ps, output int pc);
    ps = 0;
    pc = 0;
    @(negedge ref_clk_in);
    for (int k = 0; k < 400 && !(core_sample_out || core_convert_out); k++)
      @(negedge ref_clk_in);
    while (core_sample_out || core_convert_out) begin
      ps += core_sample_out;
      pc += core_convert_out;
      @(negedge ref_clk_in);
    end
  endtask

  initial begin
    repeat (16) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      chk(d, 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i][18:16], rows[i][15:8]);
      rd(rows[i][18:16], d);
      chk(d, rows[i][7:0]);
    end
    cyc(2);
    chk({core_ref_ptat_out, core_ref_gain_out, core_ref_sel_out}, 4'hd);
    wr(REG_CTRL1, 8'h00);
    cyc(2);
    chk(core_ref_sel_out, REF_PIN);
    wr(REG_SENSOR, 8'h00);
    cyc(2);
    chk(core_ref_sel_out, REF_SENSOR);
    wr(REG_PSEL_LO, 8'hc3);
    wr(REG_PSEL_HI, 8'h30);
    port_oe_in <= 8'h0f;
    cyc(2);
    chk(pin_analog_out, 8'h49);
    chk(pin_data_out, 8'hb6);
    chk(pin_pullup_out, 8'hb6);
    chk(pin_oe_out, 8'h06);
    launch(8'h07);
    phase(s, c);
    chk(16'(s), 16'h0004);
    chk(16'(c), 16'h000c);
    chk({core_ext_en_out, core_channel_out}, 4'hf);
    cyc(2);
    chk(conv_irq_out, 1'b1);
    rd(REG_CTRL0, d);
    chk(d, 8'h27);
    rd(REG_RES_HI, d);
    chk(d, 8'hff);
    rd(REG_RES_LO, d);
    chk(d, 8'hf0);
    wr(REG_CTRL1, 8'h80);
    rd(REG_RES_HI, d);
    chk(d, 8'h0f);
    rd(REG_RES_LO, d);
    chk(d, 8'hff);
    wr(REG_INT, 8'h03);
    cyc(2);
    chk(conv_irq_out, 1'b0);
    rd(REG_INT, d);
    chk(d, 8'h03);
    wr(REG_INT, 8'h06);
    wr(REG_CTRL1, 8'h00);
    wr(REG_SENSOR, 8'h01);
    launch(8'h08);
    phase(s, c);
    chk(16'(s), 16'h002c);
    chk(16'(c), 16'h000c);
    chk(core_temp_en_out, 1'b1);
    rd(REG_RES_HI, d);
    chk(d, 8'h85);
    wr(REG_SENSOR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(REG_CTRL1, 8'(i));
      launch(8'h07);
      rd(REG_CTRL0, d);
      chk(d, 8'h67);
      phase(s, c);
      chk(16'(c), 16'(12 << i));
    end
    wr(REG_CTRL1, 8'h00);
    launch(8'h07);
    for (n = 0; n < 40 && !core_convert_out; n++)
      cyc(1);
    launch(8'h07);
    phase(s, c);
    chk(16'(s), 16'h0004);
    chk(16'(c), 16'h000c);
    wr(REG_INT, 8'h06);
    launch(8'h07);
    for (n = 0; n < 40 && !conv_irq_out; n++)
      cyc(1);
    chk(conv_irq_out, 1'b1);
    wr(REG_INT, 8'h06);
    launch(8'h07);
    cyc(2);
    wr(REG_CTRL0, 8'h07);
    cyc(3);
    chk({core_power_out, core_sample_out, core_convert_out}, 3'h0);
    chk(conv_tick_out, 1'b0);
    rd(REG_INT, d);
    chk(d, 8'h06);
    rd(REG_RES_HI, d);
    chk(d, 8'hff);
    end_sim();
  end
endmodule
